// file: hw/pmw_pkg.sv
`default_nettype none
package pmw_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_RESET_SOURCE = 8'h04;
  localparam logic [7:0] ADDR_SUPPLY = 8'h08;
  localparam logic [7:0] ADDR_FLASH = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MODE_W = 3;
  localparam int RS_PIN = 0;
  localparam int RS_MONSEL = 1;
  localparam int RS_PFAIL = 2;
  localparam int RS_SW = 4;
  localparam int RS_FERR = 6;
  localparam int RS_POR = 7;
  localparam int SUP_MON_EN = 0;
  localparam int SUP_TWO_CELL = 1;
  localparam int FL_WE = 0;
  localparam int FL_WRITE = 1;
  localparam int FL_ERASE = 2;
  localparam int ST_MODE = 0;
  localparam int ST_WAKE = 3;

  // Wake source bits, also used as the status wake field
  localparam int W_IRQ = 0;
  localparam int W_RTC = 1;
  localparam int W_PORT = 2;
  localparam int W_CMP0 = 3;
  localparam int W_PIN = 4;
  localparam int WAKE_W = 5;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic MON_EN_RST = 1'h1;
  localparam logic MON_SEL_RST = 1'h1;
  localparam logic TWO_CELL_RST = 1'h1;

  typedef enum logic [2:0] {
    PMW_NORMAL = 3'h0,
    PMW_IDLE = 3'h1,
    PMW_STOP = 3'h2,
    PMW_SUSPEND = 3'h3,
    PMW_SLEEP = 3'h4
  } pmw_mode_type;
endpackage
`default_nettype wire

// file: hw/pmw_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pmw_link_if;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  pmw_pkg::pmw_mode_type mode;
  logic two_cell;
  logic [pmw_pkg::WAKE_W-1:0] src;
  logic [pmw_pkg::WAKE_W-1:0] hit;
  logic wake;

  modport bus (output wr, output addr, output wdata, input rdata);
  modport core (input wr, input addr, input wdata, output rdata, output mode, output two_cell,
                output src, input hit, input wake);
  modport wk (input mode, input two_cell, input src, output hit, output wake);
endinterface
`default_nettype wire

// file: hw/pmw_wb_slave.sv
`timescale 1ns/1ps
`default_nettype none
module pmw_wb_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic cyc,
  input wire logic stb,
  input wire logic we,
  input wire logic [7:0] adr,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel,
  output logic ack,
  output logic [31:0] dat_o,
  pmw_link_if.bus lk
);
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pmw_slave_type;

  pmw_slave_type s_r;
  pmw_slave_type s_nxt;
  logic req;

  // Decode and answer in the same edge; the ack drops one cycle later
  always_comb
  begin
    req = cyc && stb && !s_r.ack;
    s_nxt = s_r;
    s_nxt.ack = req;
    s_nxt.dat = '0;
    if (req && !we)
    begin
      s_nxt.dat[7:0] = lk.rdata;
    end
    lk.wr = req && we && sel[0];
    lk.addr = adr;
    lk.wdata = dat_i[7:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign ack = s_r.ack;
  assign dat_o = s_r.dat;

  chk_ack_single_pulse: assert property (@(posedge clk) disable iff (rst) ack |=> !ack)
    else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// file: hw/pmw_wake.sv
`timescale 1ns/1ps
`default_nettype none
module pmw_wake (
  input wire logic clk,
  input wire logic rst,
  pmw_link_if.wk lk
);
  always_comb
  begin
    lk.hit = '0;
    unique case (lk.mode)
      pmw_pkg::PMW_NORMAL:
      begin
        lk.hit = '0;
      end
      pmw_pkg::PMW_IDLE:
      begin
        lk.hit[pmw_pkg::W_IRQ] = lk.src[pmw_pkg::W_IRQ];
      end
      pmw_pkg::PMW_STOP:
      begin
        lk.hit = '0;
      end
      pmw_pkg::PMW_SUSPEND:
      begin
        lk.hit = lk.src;
        lk.hit[pmw_pkg::W_IRQ] = 1'h0;
      end
      pmw_pkg::PMW_SLEEP:
      begin
        lk.hit = lk.src;
        lk.hit[pmw_pkg::W_IRQ] = 1'h0;
        lk.hit[pmw_pkg::W_CMP0] = lk.src[pmw_pkg::W_CMP0] && lk.two_cell;
      end
    endcase
    lk.wake = |lk.hit;
  end

  chk_stop_no_wake: assert property (@(posedge clk) disable iff (rst)
    (lk.mode == pmw_pkg::PMW_STOP || lk.mode == pmw_pkg::PMW_NORMAL) |-> !lk.wake)
    else $error("wake raised in a mode without wake sources");
endmodule
`default_nettype wire

// file: hw/pmw_top.sv
`timescale 1ns/1ps
`default_nettype none
module pmw_top (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic IRQ_ANY,
  input wire logic RTC_EVENT,
  input wire logic PORT_MATCH,
  input wire logic CMP0_EVENT,
  input wire logic RST_PIN_N,
  input wire logic PFAIL,
  output logic CPU_HALT,
  output logic PREC_OSC_EN,
  output logic INT_OSC_EN,
  output logic SYSCLK_EN,
  output logic PERIPH_CLK_EN,
  output logic SUPPLY_GATE,
  output logic SUPPLY_MON_EN,
  output logic PFAIL_RST_ARMED,
  output logic DEVICE_RESET,
  output logic FLASH_WRITE_GO,
  output logic FLASH_ERASE_GO
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    pmw_pkg::pmw_mode_type mode;
    logic mon_en;
    logic mon_sel;
    logic two_cell;
    logic flash_we;
    logic c_por;
    logic c_pfail;
    logic c_pin;
    logic c_sw;
    logic c_ferr;
    logic [pmw_pkg::WAKE_W-1:0] wake_src;
    logic halt;
    logic prec_osc;
    logic int_osc;
    logic sysclk;
    logic periph;
    logic supply_gate;
    logic mon_act;
    logic armed;
    logic dev_rst;
    logic fl_wr;
    logic fl_er;
  } pmw_core_type;

  pmw_core_type s_r;
  pmw_core_type s_nxt;
  pmw_link_if lk ();

  logic wr_mode;
  logic wr_rsrc;
  logic wr_sup;
  logic wr_flash;
  logic low_pwr;
  logic pin_rst;
  logic pf_rst;
  logic sw_rst;
  logic fl_cmd;
  logic fl_bad;
  logic any_rst;
  logic mode_ok;
  pmw_pkg::pmw_mode_type req_mode;

  // ----------------------------------------
  // Sub blocks
  // ----------------------------------------
  pmw_wb_slave u_slave (
    .clk(CLOCK),
    .rst(RST),
    .cyc(WB_CYC_I),
    .stb(WB_STB_I),
    .we(WB_WE_I),
    .adr(WB_ADR_I),
    .dat_i(WB_DAT_I),
    .sel(WB_SEL_I),
    .ack(WB_ACK_O),
    .dat_o(WB_DAT_O),
    .lk(lk.bus)
  );

  pmw_wake u_wake (
    .clk(CLOCK),
    .rst(RST),
    .lk(lk.wk)
  );

  assign lk.mode = s_r.mode;
  assign lk.two_cell = s_r.two_cell;
  assign lk.src = {!RST_PIN_N, CMP0_EVENT, PORT_MATCH, RTC_EVENT, IRQ_ANY};

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  always_comb
  begin
    lk.rdata = '0;
    case (lk.addr)
      pmw_pkg::ADDR_MODE:
      begin
        lk.rdata[pmw_pkg::MODE_W-1:0] = s_r.mode;
      end
      pmw_pkg::ADDR_RESET_SOURCE:
      begin
        lk.rdata[pmw_pkg::RS_PIN] = s_r.c_pin;
        lk.rdata[pmw_pkg::RS_MONSEL] = s_r.mon_sel;
        lk.rdata[pmw_pkg::RS_PFAIL] = s_r.c_pfail;
        lk.rdata[pmw_pkg::RS_SW] = s_r.c_sw;
        lk.rdata[pmw_pkg::RS_FERR] = s_r.c_ferr;
        lk.rdata[pmw_pkg::RS_POR] = s_r.c_por;
      end
      pmw_pkg::ADDR_SUPPLY:
      begin
        lk.rdata[pmw_pkg::SUP_MON_EN] = s_r.mon_en;
        lk.rdata[pmw_pkg::SUP_TWO_CELL] = s_r.two_cell;
      end
      pmw_pkg::ADDR_FLASH:
      begin
        lk.rdata[pmw_pkg::FL_WE] = s_r.flash_we;
      end
      pmw_pkg::ADDR_STATUS:
      begin
        lk.rdata[pmw_pkg::ST_MODE+pmw_pkg::MODE_W-1:pmw_pkg::ST_MODE] = s_r.mode;
        lk.rdata[pmw_pkg::ST_WAKE+pmw_pkg::WAKE_W-1:pmw_pkg::ST_WAKE] = s_r.wake_src;
      end
      default:
      begin
        lk.rdata = '0;
      end
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.fl_wr = 1'h0;
    s_nxt.fl_er = 1'h0;
    wr_mode = lk.wr && (lk.addr == pmw_pkg::ADDR_MODE);
    wr_rsrc = lk.wr && (lk.addr == pmw_pkg::ADDR_RESET_SOURCE);
    wr_sup = lk.wr && (lk.addr == pmw_pkg::ADDR_SUPPLY);
    wr_flash = lk.wr && (lk.addr == pmw_pkg::ADDR_FLASH);
    low_pwr = (s_r.mode == pmw_pkg::PMW_SUSPEND) || (s_r.mode == pmw_pkg::PMW_SLEEP);
    // In suspend and sleep the pin is a wake source, elsewhere a reset
    pin_rst = !RST_PIN_N && !low_pwr;
    pf_rst = PFAIL && s_r.mon_en && s_r.mon_sel && (s_r.mode != pmw_pkg::PMW_SLEEP);
    sw_rst = wr_rsrc && lk.wdata[pmw_pkg::RS_SW];
    fl_cmd = wr_flash && s_r.flash_we && (lk.wdata[pmw_pkg::FL_WRITE] || lk.wdata[pmw_pkg::FL_ERASE]);
    fl_bad = fl_cmd && !(s_r.mon_en && s_r.mon_sel);
    any_rst = pin_rst || pf_rst || sw_rst || fl_bad;
    req_mode = pmw_pkg::pmw_mode_type'(lk.wdata[pmw_pkg::MODE_W-1:0]);
    mode_ok = (req_mode == pmw_pkg::PMW_IDLE) || (req_mode == pmw_pkg::PMW_STOP)
      || (req_mode == pmw_pkg::PMW_SUSPEND) || (req_mode == pmw_pkg::PMW_SLEEP);
    if (any_rst)
    begin
      s_nxt.mode = pmw_pkg::PMW_NORMAL;
      s_nxt.flash_we = 1'h0;
      s_nxt.c_pin = pin_rst;
      s_nxt.c_pfail = pf_rst;
      s_nxt.c_sw = sw_rst;
      s_nxt.c_ferr = fl_bad;
      s_nxt.c_por = pf_rst;
      if (pf_rst)
      begin
        s_nxt.mon_en = 1'h1;
        s_nxt.mon_sel = 1'h1;
      end
    end
    else
    begin
      if (wr_rsrc)
      begin
        s_nxt.mon_sel = lk.wdata[pmw_pkg::RS_MONSEL];
      end
      if (wr_sup)
      begin
        s_nxt.mon_en = lk.wdata[pmw_pkg::SUP_MON_EN];
        s_nxt.two_cell = lk.wdata[pmw_pkg::SUP_TWO_CELL];
      end
      if (wr_flash)
      begin
        s_nxt.flash_we = lk.wdata[pmw_pkg::FL_WE];
        s_nxt.fl_wr = fl_cmd && lk.wdata[pmw_pkg::FL_WRITE];
        s_nxt.fl_er = fl_cmd && !lk.wdata[pmw_pkg::FL_WRITE];
      end
      if (wr_mode && (s_r.mode == pmw_pkg::PMW_NORMAL) && mode_ok)
      begin
        s_nxt.mode = req_mode;
      end
      else if (lk.wake)
      begin
        s_nxt.mode = pmw_pkg::PMW_NORMAL;
        s_nxt.wake_src = lk.hit;
      end
    end
    s_nxt.dev_rst = any_rst;
    s_nxt.halt = (s_nxt.mode != pmw_pkg::PMW_NORMAL);
    s_nxt.prec_osc = (s_nxt.mode == pmw_pkg::PMW_NORMAL) || (s_nxt.mode == pmw_pkg::PMW_IDLE);
    s_nxt.int_osc = (s_nxt.mode != pmw_pkg::PMW_SUSPEND) && (s_nxt.mode != pmw_pkg::PMW_SLEEP);
    s_nxt.sysclk = s_nxt.int_osc;
    s_nxt.periph = s_nxt.int_osc;
    s_nxt.supply_gate = (s_nxt.mode == pmw_pkg::PMW_SLEEP);
    s_nxt.mon_act = s_nxt.mon_en && !s_nxt.supply_gate;
    s_nxt.armed = s_nxt.mon_act && s_nxt.mon_sel;
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      s_r <= '0;
      s_r.mode <= pmw_pkg::PMW_NORMAL;
      s_r.mon_en <= pmw_pkg::MON_EN_RST;
      s_r.mon_sel <= pmw_pkg::MON_SEL_RST;
      s_r.mon_act <= pmw_pkg::MON_EN_RST;
      s_r.armed <= pmw_pkg::MON_SEL_RST;
      s_r.two_cell <= pmw_pkg::TWO_CELL_RST;
      s_r.c_por <= 1'h1;
      s_r.prec_osc <= 1'h1;
      s_r.int_osc <= 1'h1;
      s_r.sysclk <= 1'h1;
      s_r.periph <= 1'h1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign CPU_HALT = s_r.halt;
  assign PREC_OSC_EN = s_r.prec_osc;
  assign INT_OSC_EN = s_r.int_osc;
  assign SYSCLK_EN = s_r.sysclk;
  assign PERIPH_CLK_EN = s_r.periph;
  assign SUPPLY_GATE = s_r.supply_gate;
  assign SUPPLY_MON_EN = s_r.mon_act;
  assign PFAIL_RST_ARMED = s_r.armed;
  assign DEVICE_RESET = s_r.dev_rst;
  assign FLASH_WRITE_GO = s_r.fl_wr;
  assign FLASH_ERASE_GO = s_r.fl_er;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_mode_legal: assert property (@(posedge CLOCK) disable iff (RST)
    s_r.mode inside {pmw_pkg::PMW_NORMAL, pmw_pkg::PMW_IDLE, pmw_pkg::PMW_STOP,
                     pmw_pkg::PMW_SUSPEND, pmw_pkg::PMW_SLEEP})
    else $error("illegal power mode");
  chk_idle_irq_wake: assert property (@(posedge CLOCK) disable iff (RST)
    (s_r.mode == pmw_pkg::PMW_IDLE && IRQ_ANY) |=> (s_r.mode == pmw_pkg::PMW_NORMAL) && s_r.periph)
    else $error("idle not left on interrupt");
  chk_stop_hold: assert property (@(posedge CLOCK) disable iff (RST)
    (s_r.mode == pmw_pkg::PMW_STOP && !any_rst) |=> (s_r.mode == pmw_pkg::PMW_STOP) && !PREC_OSC_EN)
    else $error("stop left without reset");
  chk_suspend_gate: assert property (@(posedge CLOCK) disable iff (RST)
    (s_r.mode == pmw_pkg::PMW_SUSPEND) |-> !SYSCLK_EN && !INT_OSC_EN && !PREC_OSC_EN && CPU_HALT)
    else $error("clocks running in suspend");
  chk_sleep_power: assert property (@(posedge CLOCK) disable iff (RST)
    (s_r.mode == pmw_pkg::PMW_SLEEP) |-> SUPPLY_GATE && !PERIPH_CLK_EN && !PFAIL_RST_ARMED)
    else $error("sleep not gating supply");
  chk_cmp0_cell: assert property (@(posedge CLOCK) disable iff (RST)
    (s_r.mode == pmw_pkg::PMW_SLEEP && !s_r.two_cell && !lk.wr && RST_PIN_N && !RTC_EVENT
     && !PORT_MATCH) |=> (s_r.mode == pmw_pkg::PMW_SLEEP))
    else $error("sleep left on comparator in one-cell mode");
  chk_flash_guard: assert property (@(posedge CLOCK) disable iff (RST)
    fl_bad |=> DEVICE_RESET && s_r.c_ferr && !FLASH_WRITE_GO && !FLASH_ERASE_GO)
    else $error("flash modified without supply monitor");
  chk_pfail_rearm: assert property (@(posedge CLOCK) disable iff (RST)
    pf_rst |=> s_r.mon_en && s_r.mon_sel && s_r.c_por && DEVICE_RESET)
    else $error("power-fail did not rearm monitor");
  chk_sw_keep_mon: assert property (@(posedge CLOCK) disable iff (RST)
    (sw_rst && !pf_rst) |=> $stable(s_r.mon_en) && (s_r.mon_sel == $past(s_r.mon_sel)))
    else $error("software reset changed monitor settings");
  chk_wake_clocks: assert property (@(posedge CLOCK) disable iff (RST)
    (lk.wake && !any_rst) |=> !CPU_HALT && SYSCLK_EN && (s_r.mode == pmw_pkg::PMW_NORMAL))
    else $error("wake without clocks restored");
endmodule
`default_nettype wire

// file: dv/pmw_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmw_src_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] which,
  output logic irq,
  output logic rtc,
  output logic port_match,
  output logic cmp0,
  output logic rst_pin_n,
  output logic pfail
);
  // Each request becomes a one-cycle event; all lines rest inactive between events
  logic [5:0] ev_r = 6'h00;
  always @(posedge clk)
  begin
    ev_r <= go ? (6'h01 << which) : 6'h00;
  end
  assign irq = ev_r[0];
  assign rtc = ev_r[1];
  assign port_match = ev_r[2];
  assign cmp0 = ev_r[3];
  // Pin is active low, so it rests high
  assign rst_pin_n = ~ev_r[4];
  assign pfail = ev_r[5];
endmodule
`default_nettype wire

// file: dv/tb_power_mode_wake_flash_guard.sv
`timescale 1ns/1ps
`default_nettype none
module tb_power_mode_wake_flash_guard;
  localparam logic [7:0] A_RSRC = pmw_pkg::ADDR_RESET_SOURCE;
  localparam logic [7:0] A_FL = pmw_pkg::ADDR_FLASH;
  localparam logic [7:0] A_SUP = pmw_pkg::ADDR_SUPPLY;
  localparam logic [7:0] A_MD = pmw_pkg::ADDR_MODE;
  localparam logic [7:0] A_ST = pmw_pkg::ADDR_STATUS;
  localparam int IRQ = 0, RTC = 1, PRT = 2, CMP = 3, PIN = 4, PWF = 5;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic go = 1'b0;
  logic [2:0] which = 3'h0;
  logic [31:0] dat_o;
  logic ack, irq, rtc, prt, cmp, pin_n, pwf, halt, posc, iosc, sclk, pclk, sgate, mon, armed, dres, wgo, ego;
  int n_errors = 0;
  int checks_done = 0;
  int n_rst = 0;
  int n_wgo = 0;
  int n_ego = 0;

  pmw_top uut (.CLOCK(clock), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_DAT_I(dat), .WB_SEL_I(sel), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .IRQ_ANY(irq), .RTC_EVENT(rtc),
    .PORT_MATCH(prt), .CMP0_EVENT(cmp), .RST_PIN_N(pin_n), .PFAIL(pwf), .CPU_HALT(halt),
    .PREC_OSC_EN(posc), .INT_OSC_EN(iosc), .SYSCLK_EN(sclk), .PERIPH_CLK_EN(pclk), .SUPPLY_GATE(sgate),
    .SUPPLY_MON_EN(mon), .PFAIL_RST_ARMED(armed), .DEVICE_RESET(dres), .FLASH_WRITE_GO(wgo),
    .FLASH_ERASE_GO(ego));
  pmw_src_model src (.clk(clock), .go(go), .which(which), .irq(irq), .rtc(rtc), .port_match(prt),
    .cmp0(cmp), .rst_pin_n(pin_n), .pfail(pwf));

  // ----------------------------------------
  // Clock and pulse counters
  // ----------------------------------------
  initial
  begin
    forever #50 clock = ~clock;
  end
  // Pulses are one cycle wide, so counting them beats trying to catch them
  always @(posedge clock)
  begin
    if (!rst)
    begin
      n_rst <= n_rst + ((dres === 1'b1) ? 1 : 0);
      n_wgo <= n_wgo + ((wgo === 1'b1) ? 1 : 0);
      n_ego <= n_ego + ((ego === 1'b1) ? 1 : 0);
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    sel <= 4'h1;
    // Request stands until ack is sampled high at a rising edge; only the watchdog ends a hang
    do
    begin
      @(posedge clock);
    end
    while (ack !== 1'b1);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic ev(input int k);
    @(posedge clock);
    go <= 1'b1;
    which <= k[2:0];
    @(posedge clock);
    go <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic outs(input logic [7:0] e);
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk("power outputs", e, {halt, posc, iosc, sclk, pclk, sgate, mon, armed});
  endtask
  task automatic cnts(input int r, input int w, input int x);
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("resets", r[7:0], n_rst[7:0]);
    chk("write go", w[7:0], n_wgo[7:0]);
    chk("erase go", x[7:0], n_ego[7:0]);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (8000) @(posedge clock);
    n_errors++;
    $display("BAD watchdog expected done seen hang");
    stop_test();
  end
  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd(A_MD, 8'h00);
    rd(A_RSRC, 8'h82);
    rd(A_SUP, 8'h03);
    rd(8'h20, 8'h00);
    outs(8'h7b);
    wr(A_FL, 8'h02);
    cnts(0, 0, 0);
    $display("test reset done");
    wr(A_MD, 8'h01);
    outs(8'hfb);
    ev(RTC);
    outs(8'hfb);
    ev(IRQ);
    outs(8'h7b);
    rd(A_ST, 8'h08);
    $display("test idle done");
    wr(A_MD, 8'h02);
    outs(8'hbb);
    ev(IRQ);
    outs(8'hbb);
    ev(PIN);
    outs(8'h7b);
    cnts(1, 0, 0);
    rd(A_RSRC, 8'h03);
    $display("test stop done");
    wr(A_MD, 8'h03);
    outs(8'h83);
    ev(IRQ);
    outs(8'h83);
    ev(PRT);
    outs(8'h7b);
    rd(A_ST, 8'h20);
    wr(A_MD, 8'h03);
    ev(PIN);
    outs(8'h7b);
    cnts(1, 0, 0);
    $display("test suspend done");
    wr(A_MD, 8'h04);
    outs(8'h84);
    ev(PWF);
    cnts(1, 0, 0);
    ev(IRQ);
    outs(8'h84);
    ev(RTC);
    outs(8'h7b);
    rd(A_SUP, 8'h03);
    wr(A_SUP, 8'h01);
    wr(A_MD, 8'h04);
    ev(CMP);
    outs(8'h84);
    ev(RTC);
    outs(8'h7b);
    wr(A_SUP, 8'h03);
    wr(A_MD, 8'h04);
    ev(CMP);
    outs(8'h7b);
    rd(A_ST, 8'h40);
    $display("test sleep done");
    wr(A_FL, 8'h01);
    wr(A_FL, 8'h03);
    wr(A_FL, 8'h01);
    wr(A_FL, 8'h05);
    cnts(1, 1, 1);
    wr(A_SUP, 8'h02);
    wr(A_FL, 8'h01);
    wr(A_FL, 8'h03);
    cnts(2, 1, 1);
    rd(A_RSRC, 8'h42);
    rd(A_SUP, 8'h02);
    outs(8'h78);
    wr(A_SUP, 8'h03);
    // Clearing the select bit while still writing the power-on flag as one
    wr(A_RSRC, 8'h80);
    wr(A_FL, 8'h01);
    wr(A_FL, 8'h05);
    cnts(3, 1, 1);
    rd(A_RSRC, 8'h40);
    outs(8'h7a);
    wr(A_FL, 8'h01);
    // Re-select the monitor after enabling flash writes, by direct assignment
    wr(A_RSRC, 8'h82);
    wr(A_FL, 8'h03);
    cnts(3, 2, 1);
    $display("test flash done");
    wr(A_SUP, 8'h02);
    wr(A_RSRC, 8'h90);
    cnts(4, 2, 1);
    rd(A_RSRC, 8'h12);
    rd(A_SUP, 8'h02);
    ev(PWF);
    cnts(4, 2, 1);
    wr(A_SUP, 8'h03);
    ev(PWF);
    cnts(5, 2, 1);
    rd(A_RSRC, 8'h86);
    outs(8'h7b);
    $display("test resets done");
    stop_test();
  end
endmodule
`default_nettype wire
